// ---- ext_space_model.sv ----
// Behavioural model of the extended register space behind the decoder.
`timescale 1ns/1ps
`default_nettype none

module ext_space_model (
  input  wire logic       clk_i,
  input  wire logic       ext_read_i,
  input  wire logic       ext_write_i,
  input  wire logic [7:0] ext_addr_i,
  input  wire logic [7:0] ext_wdata_i,
  output logic      [7:0] ext_rdata_o
);
  // ****************************************
  // Storage and read return
  // ****************************************
  logic [7:0] store [256];
  logic [7:0] last;

  initial begin
    for (int i = 0; i < 256; i++) begin
      store[i] = 8'h00;
    end
    last = 8'h00;
  end

  // Only loads and stores reach this space.
  always @(posedge clk_i) begin
    if (ext_write_i) begin
      store[ext_addr_i] <= ext_wdata_i;
    end
    if (ext_read_i) begin
      last <= store[ext_addr_i];
    end
  end

  // The bus shows inverted stale data outside a read, so that a late
  // sample by the decoder cannot pass for good data.
  assign ext_rdata_o = ext_read_i ? store[ext_addr_i] : ~last;

endmodule : ext_space_model

`default_nettype wire

// ---- flag_reg.sv ----
// One register of status flags, set by hardware and cleared by a one.
`timescale 1ns/1ps
`default_nettype none
`include "io_register_space_decode_params.svh"

module flag_reg
  import io_space_pkg::*;
#(
  parameter logic [7:0] MASK = `MASK_FULL
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] clear_i,
  output logic      [7:0] flags_o
);

  flag_state_t st;
  flag_state_t next_st;

  // A flag raised in the cycle it is cleared stays raised.
  always_comb begin
    next_st.flags = ((st.flags & ~clear_i) | set_i) & MASK;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{flags: `RST_REG};
    end else begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;

endmodule : flag_reg
`default_nettype wire

// ---- io_register_space_decode.sv ----
// Decoder and storage for the low I/O register space of the core.
`timescale 1ns/1ps
`default_nettype none
`include "io_register_space_decode_params.svh"

module io_register_space_decode
  import io_space_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       io_read_i,
  input  wire logic       io_write_i,
  input  wire logic [5:0] io_addr_i,
  input  wire logic       bit_set_i,
  input  wire logic       bit_clear_i,
  input  wire logic       bit_test_i,
  input  wire logic       test_for_set_i,
  input  wire logic [2:0] bit_num_i,
  input  wire logic       mem_read_i,
  input  wire logic       mem_write_i,
  input  wire logic [7:0] mem_addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  output logic            skip_o,
  output logic            ext_read_o,
  output logic            ext_write_o,
  output logic      [7:0] ext_addr_o,
  output logic      [7:0] ext_wdata_o,
  input  wire logic [7:0] ext_rdata_i,
  input  wire logic [7:0] pin_a_i,
  input  wire logic [7:0] pin_b_i,
  input  wire logic [7:0] pin_c_i,
  input  wire logic [7:0] pin_d_i,
  output logic      [7:0] port_a_out_o,
  output logic      [7:0] port_a_dir_o,
  output logic      [7:0] port_b_out_o,
  output logic      [7:0] port_b_dir_o,
  output logic      [7:0] port_c_out_o,
  output logic      [7:0] port_c_dir_o,
  output logic      [7:0] port_d_out_o,
  output logic      [7:0] port_d_dir_o,
  input  wire logic [7:0] timer0_flag_set_i,
  input  wire logic [7:0] timer1_flag_set_i,
  input  wire logic [7:0] timer2_flag_set_i,
  input  wire logic [7:0] pin_chg_flag_set_i,
  input  wire logic [7:0] ext_irq_flag_set_i,
  output logic      [7:0] timer0_flags_o,
  output logic      [7:0] timer1_flags_o,
  output logic      [7:0] timer2_flags_o,
  output logic      [7:0] pin_chg_flags_o,
  output logic      [7:0] ext_irq_flags_o,
  output logic      [7:0] ext_irq_mask_o,
  output logic      [7:0] nvm_control_o
);

  // ****************************************
  // Flag registers
  // ****************************************
  localparam int NFLAG = 5;
  localparam logic [NFLAG-1:0][5:0] FLAG_OFF = {
    `OFF_EXT_IRQ_FLAGS, `OFF_PIN_CHG_FLAGS, `OFF_TIMER2_FLAGS,
    `OFF_TIMER1_FLAGS, `OFF_TIMER0_FLAGS};
  localparam logic [NFLAG-1:0][7:0] FLAG_MASK = {
    `MASK_EXT_IRQ, `MASK_PIN_CHG, `MASK_TIMER2_FLAGS,
    `MASK_TIMER1_FLAGS, `MASK_TIMER0_FLAGS};

  logic [NFLAG-1:0][7:0] flag_set;
  logic [NFLAG-1:0][7:0] flag_clr;
  logic [NFLAG-1:0][7:0] flag_val;

  assign flag_set = {ext_irq_flag_set_i, pin_chg_flag_set_i,
                     timer2_flag_set_i, timer1_flag_set_i,
                     timer0_flag_set_i};

  for (genvar g = 0; g < NFLAG; g++) begin : g_flag
    flag_reg #(
      .MASK (FLAG_MASK[g])
    ) u_flag (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .set_i   (flag_set[g]),
      .clear_i (flag_clr[g]),
      .flags_o (flag_val[g])
    );
  end

  // ****************************************
  // Register map
  // ****************************************
  io_state_t st;
  io_state_t next_st;

  // Unlisted and reserved locations have no writable bits and read zero.
  function automatic logic [7:0] wmask(input logic [5:0] a);
    case (a)
      `OFF_PORT_A_DIR, `OFF_PORT_A_OUT,
      `OFF_PORT_B_DIR, `OFF_PORT_B_OUT,
      `OFF_PORT_C_DIR, `OFF_PORT_C_OUT,
      `OFF_PORT_D_DIR, `OFF_PORT_D_OUT,
      `OFF_EXT_IRQ_MASK, `OFF_SCRATCH_0,
      `OFF_NVM_DATA, `OFF_NVM_ADDR_LO: wmask = `MASK_FULL;
      `OFF_NVM_CONTROL:   wmask = `MASK_NVM_CONTROL;
      `OFF_NVM_ADDR_HI:   wmask = `MASK_NVM_ADDR_HI;
      `OFF_PRESCALER:     wmask = `MASK_PRESCALER;
      `OFF_TIMER0_CTRL_A: wmask = `MASK_TIMER0_A;
      `OFF_TIMER0_CTRL_B: wmask = `MASK_TIMER0_B;
      default:            wmask = `RST_REG;
    endcase
  endfunction : wmask

  function automatic logic [7:0] io_value(input logic [5:0] a,
                                          input io_state_t s);
    case (a)
      `OFF_PORT_A_IN:     io_value = pin_a_i;
      `OFF_PORT_B_IN:     io_value = pin_b_i;
      `OFF_PORT_C_IN:     io_value = pin_c_i;
      `OFF_PORT_D_IN:     io_value = pin_d_i;
      `OFF_TIMER0_FLAGS:  io_value = flag_val[0];
      `OFF_TIMER1_FLAGS:  io_value = flag_val[1];
      `OFF_TIMER2_FLAGS:  io_value = flag_val[2];
      `OFF_PIN_CHG_FLAGS: io_value = flag_val[3];
      `OFF_EXT_IRQ_FLAGS: io_value = flag_val[4];
      default:            io_value = s.io[a] & wmask(a);
    endcase
  endfunction : io_value

  // ****************************************
  // Access decode
  // ****************************************
  // One request per cycle: bit operations win over I/O instructions,
  // which win over loads and stores.
  always_comb begin
    logic [5:0] op_addr;
    logic [7:0] op_val;
    logic [7:0] cur;
    logic [7:0] bmask;
    logic [7:0] m;
    logic       op_wr;
    logic       op_rd;
    op_addr = '0;
    op_val  = '0;
    cur     = '0;
    m       = '0;
    op_wr   = 1'b0;
    op_rd   = 1'b0;
    bmask   = 8'h01 << bit_num_i;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.skip   = 1'b0;
    next_st.ext_rd = 1'b0;
    next_st.ext_wr = 1'b0;
    flag_clr = '0;
    if (bit_set_i || bit_clear_i || bit_test_i) begin
      if (io_addr_i <= `IO_BIT_LIMIT) begin
        cur = io_value(io_addr_i, st);
        if (bit_test_i) begin
          next_st.skip = (test_for_set_i == |(cur & bmask));
        end else begin
          op_wr   = 1'b1;
          op_addr = io_addr_i;
          // The whole register is written back, flags read as one too.
          op_val  = bit_set_i ? (cur | bmask) : (cur & ~bmask);
        end
      end
    end else if (io_read_i || io_write_i) begin
      op_addr = io_addr_i;
      op_rd   = io_read_i;
      op_wr   = io_write_i;
      op_val  = wdata_i;
    end else if (mem_read_i || mem_write_i) begin
      if (mem_addr_i >= `IO_EXT_BASE) begin
        next_st.ext_rd    = mem_read_i;
        next_st.ext_wr    = mem_write_i;
        next_st.ext_addr  = mem_addr_i;
        next_st.ext_wdata = wdata_i;
      end else if (mem_addr_i >= `IO_DS_OFFSET) begin
        op_addr = 6'(mem_addr_i - `IO_DS_OFFSET);
        op_rd   = mem_read_i;
        op_wr   = mem_write_i;
        op_val  = wdata_i;
      end
    end
    if (op_rd) begin
      next_st.rdata  = io_value(op_addr, st);
      next_st.rvalid = 1'b1;
    end
    if (op_wr) begin
      m = wmask(op_addr);
      next_st.io[op_addr] = (st.io[op_addr] & ~m) | (op_val & m);
      for (int k = 0; k < NFLAG; k++) begin
        if (op_addr == FLAG_OFF[k]) begin
          flag_clr[k] = op_val;
        end
      end
    end
    // Extended read data returns a cycle later and takes the bus.
    if (st.ext_rd) begin
      next_st.rdata  = ext_rdata_i;
      next_st.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o        = st.rdata;
  assign rvalid_o       = st.rvalid;
  assign skip_o         = st.skip;
  assign ext_read_o     = st.ext_rd;
  assign ext_write_o    = st.ext_wr;
  assign ext_addr_o     = st.ext_addr;
  assign ext_wdata_o    = st.ext_wdata;
  assign port_a_out_o   = st.io[`OFF_PORT_A_OUT];
  assign port_a_dir_o   = st.io[`OFF_PORT_A_DIR];
  assign port_b_out_o   = st.io[`OFF_PORT_B_OUT];
  assign port_b_dir_o   = st.io[`OFF_PORT_B_DIR];
  assign port_c_out_o   = st.io[`OFF_PORT_C_OUT];
  assign port_c_dir_o   = st.io[`OFF_PORT_C_DIR];
  assign port_d_out_o   = st.io[`OFF_PORT_D_OUT];
  assign port_d_dir_o   = st.io[`OFF_PORT_D_DIR];
  assign timer0_flags_o  = flag_val[0];
  assign timer1_flags_o  = flag_val[1];
  assign timer2_flags_o  = flag_val[2];
  assign pin_chg_flags_o = flag_val[3];
  assign ext_irq_flags_o = flag_val[4];
  assign ext_irq_mask_o = st.io[`OFF_EXT_IRQ_MASK];
  assign nvm_control_o  = st.io[`OFF_NVM_CONTROL] & `MASK_NVM_CONTROL;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic no_bit;
  logic io_only;
  assign no_bit  = !bit_set_i && !bit_clear_i && !bit_test_i;
  assign io_only = no_bit && !io_read_i && !io_write_i;

  property p_io_write_port;
    no_bit && io_write_i && io_addr_i == `OFF_PORT_A_OUT
      |=> port_a_out_o == $past(wdata_i);
  endproperty
  a_io_write_port: assert property (p_io_write_port)
    else $error("I/O write did not reach the port output");

  property p_ds_write_alias;
    io_only && mem_write_i && mem_addr_i == 8'h22
      |=> port_a_out_o == $past(wdata_i);
  endproperty
  a_ds_write_alias: assert property (p_ds_write_alias)
    else $error("Data-space write missed the aliased register");

  property p_bit_set;
    (bit_set_i && io_addr_i == `OFF_PORT_B_OUT)
      |=> port_b_out_o[$past(bit_num_i)] == 1'b1;
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("Bit set did not set the bit");

  property p_bit_high_ignored;
    (bit_set_i || bit_clear_i) && io_addr_i > `IO_BIT_LIMIT
      |=> st.io == $past(st.io);
  endproperty
  a_bit_high_ignored: assert property (p_bit_high_ignored)
    else $error("Bit operation acted above the bit range");

  property p_skip;
    bit_test_i && io_addr_i == `OFF_PORT_A_IN
      |=> skip_o == ($past(test_for_set_i) ==
                     $past(pin_a_i[bit_num_i]));
  endproperty
  a_skip: assert property (p_skip)
    else $error("Skip result does not match the tested bit");

  property p_w1c;
    no_bit && io_write_i && io_addr_i == `OFF_EXT_IRQ_FLAGS
      && wdata_i[0] && !ext_irq_flag_set_i[0]
      |=> !ext_irq_flags_o[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("Writing one did not clear the flag");

  property p_rmw_clears;
    bit_clear_i && !bit_test_i && io_addr_i == `OFF_TIMER0_FLAGS
      && timer0_flag_set_i == 8'h00
      |=> timer0_flags_o ==
          ($past(timer0_flags_o) & (8'h01 << $past(bit_num_i)));
  endproperty
  a_rmw_clears: assert property (p_rmw_clears)
    else $error("Bit operation failed to clear flags read as one");

  property p_ext_read;
    io_only && mem_read_i && mem_addr_i >= `IO_EXT_BASE
      |=> ext_read_o && ext_addr_o == $past(mem_addr_i)
      ##1 rvalid_o && rdata_o == $past(ext_rdata_i);
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("Extended read was not forwarded");

  property p_one_store;
    no_bit && io_write_i && io_addr_i == `OFF_SCRATCH_0
      ##1 io_only && mem_read_i && mem_addr_i == 8'h3e
      |=> rvalid_o && rdata_o == $past(wdata_i, 2);
  endproperty
  a_one_store: assert property (p_one_store)
    else $error("Two paths see different storage");

  c_skip: cover property (bit_test_i ##1 skip_o);
  c_ext_wr: cover property (ext_write_o);
  c_flag_clr: cover property ($fell(ext_irq_flags_o[0]));
  c_rmw: cover property (bit_clear_i && io_addr_i == `OFF_TIMER0_FLAGS);

endmodule : io_register_space_decode
`default_nettype wire

// ---- io_register_space_decode_params.svh ----
// Offsets, field masks, reset values and timing counts of the I/O space.
`ifndef IO_REGISTER_SPACE_DECODE_PARAMS_SVH
`define IO_REGISTER_SPACE_DECODE_PARAMS_SVH

// ****************************************
// Address map
// ****************************************
`define IO_DS_OFFSET      8'h20
`define IO_EXT_BASE       8'h60
`define IO_BIT_LIMIT      6'h1f

`define OFF_PORT_A_IN     6'h00
`define OFF_PORT_A_DIR    6'h01
`define OFF_PORT_A_OUT    6'h02
`define OFF_PORT_B_IN     6'h03
`define OFF_PORT_B_DIR    6'h04
`define OFF_PORT_B_OUT    6'h05
`define OFF_PORT_C_IN     6'h06
`define OFF_PORT_C_DIR    6'h07
`define OFF_PORT_C_OUT    6'h08
`define OFF_PORT_D_IN     6'h09
`define OFF_PORT_D_DIR    6'h0a
`define OFF_PORT_D_OUT    6'h0b
`define OFF_TIMER0_FLAGS  6'h15
`define OFF_TIMER1_FLAGS  6'h16
`define OFF_TIMER2_FLAGS  6'h17
`define OFF_PIN_CHG_FLAGS 6'h1b
`define OFF_EXT_IRQ_FLAGS 6'h1c
`define OFF_EXT_IRQ_MASK  6'h1d
`define OFF_SCRATCH_0     6'h1e
`define OFF_NVM_CONTROL   6'h1f
`define OFF_NVM_DATA      6'h20
`define OFF_NVM_ADDR_LO   6'h21
`define OFF_NVM_ADDR_HI   6'h22
`define OFF_PRESCALER     6'h23
`define OFF_TIMER0_CTRL_A 6'h24
`define OFF_TIMER0_CTRL_B 6'h25

// ****************************************
// Implemented bits and reset values
// ****************************************
`define MASK_FULL         8'hff
`define MASK_TIMER0_FLAGS 8'h07
`define MASK_TIMER1_FLAGS 8'h27
`define MASK_TIMER2_FLAGS 8'h07
`define MASK_PIN_CHG      8'h0f
`define MASK_EXT_IRQ      8'h07
`define MASK_NVM_CONTROL  8'h3f
`define MASK_NVM_ADDR_HI  8'h0f
`define MASK_PRESCALER    8'h83
`define MASK_TIMER0_A     8'hf3
`define MASK_TIMER0_B     8'hcf
`define RST_REG           8'h00

// ****************************************
// Timing in clock cycles
// ****************************************
`define LAT_INTERNAL      1
`define LAT_EXTENDED      2

`endif

// ---- io_space_pkg.sv ----
// Types shared by the I/O space decoder and its flag registers.
package io_space_pkg;

  typedef struct packed {
    logic [63:0][7:0] io;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             skip;
    logic             ext_rd;
    logic             ext_wr;
    logic [7:0]       ext_addr;
    logic [7:0]       ext_wdata;
  } io_state_t;

  typedef struct packed {
    logic [7:0] flags;
  } flag_state_t;

endpackage : io_space_pkg

// ---- tb.sv ----
// Self-checking bench for the I/O register space decoder.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ****************************************
  // Signals and stimulus table
  // ****************************************
  localparam logic [3:0] K_W = 4'h0, K_R = 4'h1, K_S = 4'h2, K_L = 4'h3;
  localparam logic [3:0] K_B = 4'h4, K_C = 4'h5, K_T = 4'h6, K_U = 4'h7;
  localparam logic [3:0] K_F = 4'h8;
  typedef struct packed {
    logic [3:0] k;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  localparam int N = 44;
  localparam row_t ROWS [N] = '{
    '{K_R, 8'h02, 8'h00, 8'h00}, '{K_R, 8'h1d, 8'h00, 8'h00},
    '{K_W, 8'h01, 8'ha5, 8'h00}, '{K_R, 8'h01, 8'h00, 8'ha5},
    '{K_L, 8'h21, 8'h00, 8'ha5}, '{K_S, 8'h22, 8'h3c, 8'h00},
    '{K_R, 8'h02, 8'h00, 8'h3c}, '{K_B, 8'h02, 8'h00, 8'h00},
    '{K_R, 8'h02, 8'h00, 8'h3d}, '{K_C, 8'h02, 8'h02, 8'h00},
    '{K_R, 8'h02, 8'h00, 8'h39}, '{K_T, 8'h02, 8'h00, 8'h01},
    '{K_T, 8'h02, 8'h01, 8'h00}, '{K_U, 8'h02, 8'h01, 8'h01},
    '{K_U, 8'h02, 8'h00, 8'h00}, '{K_W, 8'h20, 8'hff, 8'h00},
    '{K_T, 8'h20, 8'h00, 8'h00}, '{K_C, 8'h20, 8'h00, 8'h00},
    '{K_R, 8'h20, 8'h00, 8'hff}, '{K_W, 8'h00, 8'h77, 8'h00},
    '{K_R, 8'h00, 8'h00, 8'h5a}, '{K_L, 8'h23, 8'h00, 8'hc3},
    '{K_R, 8'h06, 8'h00, 8'h0f}, '{K_L, 8'h29, 8'h00, 8'he1},
    '{K_R, 8'h3f, 8'h00, 8'h00}, '{K_W, 8'h09, 8'hff, 8'h00},
    '{K_R, 8'h0c, 8'h00, 8'h00}, '{K_W, 8'h22, 8'h0f, 8'h00},
    '{K_R, 8'h22, 8'h00, 8'h0f}, '{K_S, 8'h60, 8'h96, 8'h00},
    '{K_L, 8'h60, 8'h00, 8'h96}, '{K_L, 8'hff, 8'h00, 8'h00},
    '{K_F, 8'h00, 8'hff, 8'h00}, '{K_R, 8'h16, 8'h00, 8'h27},
    '{K_R, 8'h1b, 8'h00, 8'h0f}, '{K_W, 8'h16, 8'h01, 8'h00},
    '{K_R, 8'h16, 8'h00, 8'h26}, '{K_W, 8'h16, 8'h00, 8'h00},
    '{K_R, 8'h16, 8'h00, 8'h26}, '{K_B, 8'h16, 8'h03, 8'h00},
    '{K_R, 8'h16, 8'h00, 8'h00}, '{K_C, 8'h1c, 8'h00, 8'h00},
    '{K_R, 8'h1c, 8'h00, 8'h01}, '{K_R, 8'h15, 8'h00, 8'h07}
  };
  logic       clk_i, reset_i, io_read_i, io_write_i, bit_set_i, bit_clear_i;
  logic       bit_test_i, test_for_set_i, mem_read_i, mem_write_i;
  logic       rvalid_o, skip_o, ext_read_o, ext_write_o;
  logic [2:0] bit_num_i;
  logic [5:0] io_addr_i;
  logic [7:0] mem_addr_i, wdata_i, rdata_o, ext_addr_o, ext_wdata_o;
  logic [7:0] ext_rdata_i, pin_a_i, pin_b_i, pin_c_i, pin_d_i;
  logic [7:0] port_a_out_o, port_a_dir_o, port_b_out_o, port_b_dir_o;
  logic [7:0] port_c_out_o, port_c_dir_o, port_d_out_o, port_d_dir_o;
  logic [7:0] timer0_flag_set_i, timer1_flag_set_i, timer2_flag_set_i;
  logic [7:0] pin_chg_flag_set_i, ext_irq_flag_set_i, timer0_flags_o;
  logic [7:0] timer1_flags_o, timer2_flags_o, pin_chg_flags_o;
  logic [7:0] ext_irq_flags_o, ext_irq_mask_o, nvm_control_o;
  int         fail_count, tests_run;

  io_register_space_decode u_dut (
    .clk_i, .reset_i, .io_read_i, .io_write_i, .io_addr_i, .bit_set_i,
    .bit_clear_i, .bit_test_i, .test_for_set_i, .bit_num_i, .mem_read_i,
    .mem_write_i, .mem_addr_i, .wdata_i, .rdata_o, .rvalid_o, .skip_o,
    .ext_read_o, .ext_write_o, .ext_addr_o, .ext_wdata_o, .ext_rdata_i,
    .pin_a_i, .pin_b_i, .pin_c_i, .pin_d_i, .port_a_out_o, .port_a_dir_o,
    .port_b_out_o, .port_b_dir_o, .port_c_out_o, .port_c_dir_o,
    .port_d_out_o, .port_d_dir_o, .timer0_flag_set_i, .timer1_flag_set_i,
    .timer2_flag_set_i, .pin_chg_flag_set_i, .ext_irq_flag_set_i,
    .timer0_flags_o, .timer1_flags_o, .timer2_flags_o, .pin_chg_flags_o,
    .ext_irq_flags_o, .ext_irq_mask_o, .nvm_control_o
  );

  ext_space_model u_ext (
    .clk_i(clk_i), .ext_read_i(ext_read_o), .ext_write_i(ext_write_o),
    .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o),
    .ext_rdata_o(ext_rdata_i)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  // One request held for one cycle; it is taken at the second edge.
  task automatic op(input logic [3:0] k, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk_i);
    io_read_i <= (k == K_R);
    io_write_i <= (k == K_W);
    mem_read_i <= (k == K_L);
    mem_write_i <= (k == K_S);
    bit_set_i <= (k == K_B);
    bit_clear_i <= (k == K_C);
    bit_test_i <= (k == K_T) || (k == K_U);
    test_for_set_i <= (k == K_T);
    io_addr_i <= a[5:0];
    mem_addr_i <= a;
    wdata_i <= d;
    bit_num_i <= d[2:0];
    {timer0_flag_set_i, timer1_flag_set_i, timer2_flag_set_i,
     pin_chg_flag_set_i, ext_irq_flag_set_i} <= (k == K_F) ? {5{d}} : 40'h0;
    @(posedge clk_i);
    {io_read_i, io_write_i, mem_read_i, mem_write_i} <= 4'h0;
    {bit_set_i, bit_clear_i, bit_test_i} <= 3'h0;
    {timer0_flag_set_i, timer1_flag_set_i, timer2_flag_set_i,
     pin_chg_flag_set_i, ext_irq_flag_set_i} <= 40'h0;
  endtask : op

  task automatic wait_rvalid();
    int n;
    n = 0;
    #1;
    while (rvalid_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (rvalid_o !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, rvalid_o, 1'b1);
      end_sim();
    end
  endtask : wait_rvalid

  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {io_read_i, io_write_i, bit_set_i, bit_clear_i, bit_test_i} = 5'h00;
    {test_for_set_i, mem_read_i, mem_write_i, bit_num_i} = 6'h00;
    {io_addr_i, mem_addr_i, wdata_i} = 22'h0;
    {timer0_flag_set_i, timer1_flag_set_i, timer2_flag_set_i,
     pin_chg_flag_set_i, ext_irq_flag_set_i} = 40'h0;
    {pin_a_i, pin_b_i, pin_c_i, pin_d_i} = 32'h5ac30fe1;
    fail_count = 0;
    tests_run = 0;
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < N; i++) begin
      op(ROWS[i].k, ROWS[i].a, ROWS[i].d);
      if (ROWS[i].k == K_R || ROWS[i].k == K_L) begin
        wait_rvalid();
        chk_byte(rdata_o, ROWS[i].e);
      end else if (ROWS[i].k == K_T || ROWS[i].k == K_U) begin
        #1;
        chk_bit(skip_o, ROWS[i].e[0]);
      end
    end
    chk_byte(port_a_out_o, 8'h39);
    chk_byte(port_a_dir_o, 8'ha5);
    chk_byte(ext_irq_flags_o, 8'h01);
    chk_byte(timer1_flags_o, 8'h00);
    op(K_W, 8'h1c, 8'h01);
    op(K_C, 8'h15, 8'h01);
    op(K_W, 8'h1d, 8'h05);
    op(K_S, 8'h3f, 8'h15);
    op(K_B, 8'h05, 8'h07);
    op(K_W, 8'h04, 8'h11);
    op(K_W, 8'h07, 8'h3c);
    op(K_W, 8'h08, 8'h22);
    op(K_S, 8'h2a, 8'h33);
    op(K_S, 8'h2b, 8'h81);
    #1;
    chk_byte(ext_irq_flags_o, 8'h00);
    chk_byte(timer0_flags_o, 8'h02);
    chk_byte(timer2_flags_o, 8'h07);
    chk_byte(pin_chg_flags_o, 8'h0f);
    chk_byte(ext_irq_mask_o, 8'h05);
    chk_byte(nvm_control_o, 8'h15);
    chk_byte(port_b_out_o, 8'h80);
    chk_byte(port_b_dir_o, 8'h11);
    chk_byte(port_c_dir_o, 8'h3c);
    chk_byte(port_c_out_o, 8'h22);
    chk_byte(port_d_dir_o, 8'h33);
    chk_byte(port_d_out_o, 8'h81);
    op(K_S, 8'h7f, 8'hc3);
    #1;
    chk_bit(ext_write_o, 1'b1);
    chk_byte(ext_addr_o, 8'h7f);
    chk_byte(ext_wdata_o, 8'hc3);
    op(K_L, 8'h80, 8'h00);
    #1;
    chk_bit(ext_read_o, 1'b1);
    chk_byte(ext_addr_o, 8'h80);
    // Loads below the I/O window must not answer at all.
    op(K_L, 8'h10, 8'h00);
    repeat (3) begin
      #1;
      chk_bit(rvalid_o, 1'b0);
      @(posedge clk_i);
    end
    // Back-to-back write and load of one register, no idle cycle between.
    @(posedge clk_i);
    {io_write_i, io_addr_i, wdata_i} <= {1'b1, 6'h1e, 8'h6b};
    @(posedge clk_i);
    {io_write_i, mem_read_i, mem_addr_i} <= {1'b0, 1'b1, 8'h3e};
    @(posedge clk_i);
    mem_read_i <= 1'b0;
    wait_rvalid();
    chk_byte(rdata_o, 8'h6b);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk_byte(port_a_dir_o, 8'h00);
    chk_byte(timer0_flags_o, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b0;
    op(K_R, 8'h01, 8'h00);
    wait_rvalid();
    chk_byte(rdata_o, 8'h00);
    end_sim();
  end

endmodule : tb

`default_nettype wire
